/* psbi_pkg.sv */
package psbi_pkg;
	// Pin widths for the 64 Mbit, 16-bit die
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int CFG_W = 16;
	// Array model depth kept small; only the low address bits index it
	localparam int MEM_AW = 8;
	// Clock rate and documented times
	localparam int CLK_PERIOD_NS = 8;
	localparam int CLK_MHZ = 125;
	localparam int INIT_US = 150;
	localparam int ACCESS_NS = 70;
	localparam int PAGE_NS = 25;
	// Least times round up to whole cycles
	localparam int INIT_CYC = INIT_US * CLK_MHZ;
	localparam int ACC_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PAGE_CYC = (PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
	// Configuration register fields
	localparam int BCR_BURST_BIT = 15;
	localparam int BCR_WAIT_POL_BIT = 10;
	localparam int RCR_PAGE_BIT = 7;
	localparam int RCR_DPD_N_BIT = 4;
	localparam int CFG_SEL_BIT = 19;
	localparam logic [CFG_W-1:0] BCR_RESET = 16'h0000;
	localparam logic [CFG_W-1:0] RCR_RESET = 16'h0010;
	// Page offset width within the address
	localparam int PAGE_AW = 4;
	// Synchronised pin vector width
	localparam int SYNC_W = 8 + ADDR_W + DATA_W;

	typedef enum logic [1:0] {
		PSBI_INIT = 2'b00,
		PSBI_ACTIVE = 2'b01,
		PSBI_DPD = 2'b10
	} psbi_state_type;
endpackage : psbi_pkg

/* psbi_mem_if.sv */
`timescale 1ns/1ps
interface psbi_mem_if;
	import psbi_pkg::*;
	logic we;
	logic [1:0] be;
	logic [MEM_AW-1:0] waddr;
	logic [DATA_W-1:0] wdata;
	logic [MEM_AW-1:0] raddr;
	logic [DATA_W-1:0] rdata;
	modport ctl (output we, be, waddr, wdata, raddr, input rdata);
	modport mem (input we, be, waddr, wdata, raddr, output rdata);
endinterface : psbi_mem_if

/* psbi_mem.sv */
`timescale 1ns/1ps
module psbi_mem (
	input wire logic sys_clk,
	psbi_mem_if.mem mif
);
	import psbi_pkg::*;
	logic [DATA_W-1:0] array_q [0:(1<<MEM_AW)-1];
	logic [DATA_W-1:0] rdata_q;

	// Byte-masked write, registered read; no reset so it maps to RAM
	always_ff @(posedge sys_clk) begin
		if (mif.we && mif.be[0]) begin
			array_q[mif.waddr][7:0] <= mif.wdata[7:0];
		end
		if (mif.we && mif.be[1]) begin
			array_q[mif.waddr][15:8] <= mif.wdata[15:8];
		end
		rdata_q <= array_q[mif.raddr];
	end

	assign mif.rdata = rdata_q;
endmodule : psbi_mem

/* psbi_top.sv */
`timescale 1ns/1ps
// What this block does
// - Read starts with select, output enable, byte enables low, write enable high.
// - Select, write enable, byte enables low is a write; output enable ignored.
// - Write data captured at first rising edge of select, write or byte enables.
// - Address latched on address valid rising, or followed while it stays low.
// - Wait output driven while enabled in async and page modes; host ignores it.
// - Select high gives standby: data and wait released, inputs isolated.
// - Byte enables gate lanes: both full word, low bits 7-0, high bits 15-8.
// - Deep power-down persists until the refresh configuration register is rewritten.
// - Bus configuration bit 10 sets the wait output polarity.
// - Bus configuration bit 15 selects burst mode, else asynchronous.
// - Self-initialization lasts 150 us, loading defaults; host keeps select high.
// - After initialization the interface runs asynchronously until reconfigured.
// - Page reads only when refresh configuration bit 7 is set.
// - In page mode only address bits 3-0 change; bit 4 upward fixed.
// - Writes have no page mode; each write is a single access.
// - Config select high turns a write into a config register load.
// - Burst mode latches address on first clock rise with address valid low.
// - Wait output released whenever select is high.
// - During reads disabled byte lanes stay released, enabled ones driven.
module psbi_top #(
	parameter int unsigned INIT_CYCLES = psbi_pkg::INIT_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic bus_clk,
	input wire logic address_valid_n,
	input wire logic chip_select_n,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic config_reg_select,
	input wire logic low_byte_enable_n,
	input wire logic high_byte_enable_n,
	input wire logic [psbi_pkg::ADDR_W-1:0] addr,
	input wire logic [psbi_pkg::DATA_W-1:0] dq_in,
	output logic [psbi_pkg::DATA_W-1:0] dq_out,
	output logic [1:0] dq_oe,
	output logic wait_out,
	output logic wait_oe,
	output logic init_done,
	output logic deep_power_down,
	output logic burst_mode
);
	import psbi_pkg::*;

	psbi_mem_if mif ();
	psbi_mem u_mem (.sys_clk(sys_clk), .mif(mif));

	// Three-stage pin synchroniser; a change counts once stages two and three agree
	logic [SYNC_W-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
	always_comb begin
		flt_d = (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q));
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			flt_q <= '1;
		end else begin
			s1_q <= {bus_clk, address_valid_n, chip_select_n, output_enable_n, write_enable_n,
				config_reg_select, low_byte_enable_n, high_byte_enable_n, addr, dq_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
			flt_q <= flt_d;
		end
	end

	logic f_clk, f_adv_n, f_ce_n, f_oe_n, f_we_n, f_cre, f_lb_n, f_ub_n;
	logic [ADDR_W-1:0] f_addr;
	logic [DATA_W-1:0] f_dq;
	assign {f_clk, f_adv_n, f_ce_n, f_oe_n, f_we_n, f_cre, f_lb_n, f_ub_n, f_addr, f_dq} = flt_q;

	// Control state
	psbi_state_type state_q, state_d;
	logic [CNT_W-1:0] init_cnt_q, init_cnt_d, acc_cnt_q, acc_cnt_d;
	logic [CFG_W-1:0] bcr_q, bcr_d, rcr_q, rcr_d;
	logic [ADDR_W-1:0] addr_q, addr_d, addr_prev_q;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic [1:0] wbe_q, wbe_d;
	logic wcre_q, wcre_d, wr_prev_q, rd_prev_q, clk_prev_q, blat_q, blat_d;
	logic burst_wr_q, burst_wr_d;
	logic active, bytes_on, wr_act, wr_open, rd_act, wr_end, rd_ok, addr_chg, page_hit;
	logic [DATA_W-1:0] dq_out_d;
	logic [1:0] dq_oe_d;
	logic wait_out_d, wait_oe_d;

	// Decoded cycles; a write ignores output enable since write enable overrides it
	always_comb begin
		active = (state_q == PSBI_ACTIVE) && !f_ce_n;
		bytes_on = !f_lb_n || !f_ub_n;
		wr_act = active && !f_we_n && (bytes_on || f_cre);
		rd_act = active && !f_oe_n && f_we_n && bytes_on && !f_cre && !bcr_q[BCR_BURST_BIT];
		wr_open = wr_act || (state_q == PSBI_DPD && !f_ce_n && !f_we_n && f_cre);
		wr_end = wr_prev_q && !wr_open;
		addr_chg = addr_q != addr_prev_q;
		page_hit = rcr_q[RCR_PAGE_BIT]
			&& (addr_q[ADDR_W-1:PAGE_AW] == addr_prev_q[ADDR_W-1:PAGE_AW]);
		rd_ok = rd_act && rd_prev_q && !addr_chg && (acc_cnt_q == '0);
	end

	// Next-state logic for mode, configuration, address and access timing
	always_comb begin
		state_d = state_q;
		init_cnt_d = init_cnt_q;
		bcr_d = bcr_q;
		rcr_d = rcr_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		wbe_d = wbe_q;
		wcre_d = wcre_q;
		blat_d = blat_q && !f_ce_n;
		burst_wr_d = burst_wr_q;
		acc_cnt_d = acc_cnt_q;
		mif.we = 1'b0;
		mif.be = wbe_q;
		mif.waddr = addr_q[MEM_AW-1:0];
		mif.wdata = wdata_q;
		mif.raddr = addr_q[MEM_AW-1:0];
		case (state_q)
			PSBI_INIT: begin
				// Defaults were loaded at reset; wait out self-initialization
				if (init_cnt_q == '0) begin
					state_d = PSBI_ACTIVE;
				end else begin
					init_cnt_d = init_cnt_q - 1'b1;
				end
			end
			PSBI_ACTIVE: begin
				if (f_ce_n && !rcr_q[RCR_DPD_N_BIT]) begin
					state_d = PSBI_DPD;
				end
			end
			PSBI_DPD: begin
				// Only a refresh register load wakes the die
				if (wr_end && wcre_q && !addr_q[CFG_SEL_BIT]) begin
					state_d = PSBI_ACTIVE;
				end
			end
			default: begin
				state_d = PSBI_INIT;
			end
		endcase
		// Address capture; nothing moves while deselected
		if (!f_ce_n && state_q != PSBI_INIT) begin
			if (bcr_q[BCR_BURST_BIT]) begin
				if (f_clk && !clk_prev_q && !f_adv_n && !blat_q) begin
					addr_d = f_addr;
					burst_wr_d = !f_we_n;
					blat_d = 1'b1;
				end
			end else if (!f_adv_n) begin
				addr_d = f_addr;
			end
		end
		// Hold data while the write is open, commit at its first closing edge
		if (wr_open) begin
			wdata_d = f_dq;
			wbe_d = {!f_ub_n, !f_lb_n};
			wcre_d = f_cre;
		end
		if (wr_end) begin
			if (wcre_q) begin
				if (addr_q[CFG_SEL_BIT]) begin
					if (state_q == PSBI_ACTIVE) begin
						bcr_d = addr_q[CFG_W-1:0];
					end
				end else begin
					rcr_d = addr_q[CFG_W-1:0];
				end
			end else if (state_q == PSBI_ACTIVE) begin
				mif.we = 1'b1;
			end
		end
		// Access timer: full time on a new access, short time inside a page
		if (rd_act && (!rd_prev_q || addr_chg)) begin
			acc_cnt_d = (rd_prev_q && page_hit) ? CNT_W'(PAGE_CYC) : CNT_W'(ACC_CYC);
		end else if (acc_cnt_q != '0) begin
			acc_cnt_d = acc_cnt_q - 1'b1;
		end
	end

	// Pin drivers; disabled lanes and deselect release the bus
	always_comb begin
		dq_out_d = mif.rdata;
		dq_oe_d = rd_ok ? {!f_ub_n, !f_lb_n} : 2'b00;
		wait_oe_d = !f_ce_n && state_q != PSBI_INIT;
		// Polarity bit set means active high; asserted level is shown in async modes
		wait_out_d = bcr_q[BCR_WAIT_POL_BIT];
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= PSBI_INIT;
			init_cnt_q <= CNT_W'(INIT_CYCLES);
			bcr_q <= BCR_RESET;
			rcr_q <= RCR_RESET;
			addr_q <= '0;
			addr_prev_q <= '0;
			wdata_q <= '0;
			wbe_q <= 2'b00;
			wcre_q <= 1'b0;
			wr_prev_q <= 1'b0;
			rd_prev_q <= 1'b0;
			clk_prev_q <= 1'b0;
			blat_q <= 1'b0;
			burst_wr_q <= 1'b0;
			acc_cnt_q <= '0;
			dq_out <= '0;
			dq_oe <= 2'b00;
			wait_out <= 1'b0;
			wait_oe <= 1'b0;
			init_done <= 1'b0;
			deep_power_down <= 1'b0;
			burst_mode <= 1'b0;
		end else begin
			state_q <= state_d;
			// Init time loaded at reset as a constant, counted down here
			init_cnt_q <= init_cnt_d;
			bcr_q <= bcr_d;
			rcr_q <= rcr_d;
			addr_q <= addr_d;
			addr_prev_q <= addr_q;
			wdata_q <= wdata_d;
			wbe_q <= wbe_d;
			wcre_q <= wcre_d;
			wr_prev_q <= wr_open;
			rd_prev_q <= rd_act;
			clk_prev_q <= f_clk;
			blat_q <= blat_d;
			burst_wr_q <= burst_wr_d;
			acc_cnt_q <= acc_cnt_d;
			dq_out <= dq_out_d;
			dq_oe <= dq_oe_d;
			wait_out <= wait_out_d;
			wait_oe <= wait_oe_d;
			init_done <= (state_d != PSBI_INIT);
			deep_power_down <= (state_d == PSBI_DPD);
			burst_mode <= bcr_d[BCR_BURST_BIT];
		end
	end

	// Checks next to the logic they guard
	sequence read_quiet_s;
		(dq_oe == 2'b00) [*8];
	endsequence

	AST_STANDBY_HIZ: assert property (@(posedge sys_clk) disable iff (rst)
		f_ce_n |=> (dq_oe == 2'b00) && !wait_oe)
		else $error("Bus not released while deselected");
	AST_WAIT_DRIVEN: assert property (@(posedge sys_clk) disable iff (rst)
		(!f_ce_n && state_q == PSBI_ACTIVE) |=> wait_oe && (wait_out == $past(bcr_q[BCR_WAIT_POL_BIT])))
		else $error("Wait output not driven at configured level");
	AST_LANE_LOW: assert property (@(posedge sys_clk) disable iff (rst)
		dq_oe[0] |-> $past(!f_lb_n) && $past(rd_act))
		else $error("Low lane driven without enable");
	AST_LANE_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
		dq_oe[1] |-> $past(!f_ub_n) && $past(rd_act))
		else $error("High lane driven without enable");
	AST_READ_LATENCY: assert property (@(posedge sys_clk) disable iff (rst)
		(rd_act && !rd_prev_q) |=> read_quiet_s)
		else $error("Read data driven before access time");
	AST_WRITE_COMMIT: assert property (@(posedge sys_clk) disable iff (rst)
		(wr_end && !wcre_q && state_q == PSBI_ACTIVE) |-> mif.we && mif.waddr == addr_q[MEM_AW-1:0])
		else $error("Array write not committed at closing edge");
	AST_CFG_NO_ARRAY: assert property (@(posedge sys_clk) disable iff (rst)
		(wr_end && wcre_q && (state_q == PSBI_ACTIVE || !addr_q[CFG_SEL_BIT])) |-> !mif.we
			##1 (($past(addr_q[CFG_SEL_BIT]) ? bcr_q : rcr_q) == $past(addr_q[CFG_W-1:0])))
		else $error("Config write reached the array or missed a register");
	AST_DPD_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		(state_q == PSBI_DPD && !(wr_end && wcre_q)) |=> state_q == PSBI_DPD)
		else $error("Left deep power-down without refresh register write");
	AST_INIT_END: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(init_done) |-> $past(init_cnt_q) == '0 && bcr_q[BCR_BURST_BIT] == 1'b0)
		else $error("Initialization ended early or not in async mode");
	AST_PAGE_TIME: assert property (@(posedge sys_clk) disable iff (rst)
		(rd_act && rd_prev_q && addr_chg) |=> acc_cnt_q == (($past(page_hit)) ? CNT_W'(PAGE_CYC)
			: CNT_W'(ACC_CYC)))
		else $error("Wrong access time after address change");
	AST_BURST_LATCH: assert property (@(posedge sys_clk) disable iff (rst)
		(bcr_q[BCR_BURST_BIT] && !f_ce_n && state_q != PSBI_INIT && f_clk && !clk_prev_q
			&& !f_adv_n && !blat_q) |=> addr_q == $past(f_addr) && burst_wr_q == $past(!f_we_n)
			&& blat_q)
		else $error("Burst address or direction not latched");
endmodule : psbi_top

/* psbi_host.sv */
`timescale 1ns/1ps
// Host controller model; SRAM-style cycles, plus one bus clock pulse for a burst start
module psbi_host (
	input wire logic sys_clk,
	output logic bus_clk,
	output logic address_valid_n,
	output logic chip_select_n,
	output logic output_enable_n,
	output logic write_enable_n,
	output logic config_reg_select,
	output logic low_byte_enable_n,
	output logic high_byte_enable_n,
	output logic [psbi_pkg::ADDR_W-1:0] addr,
	output logic [psbi_pkg::DATA_W-1:0] dq_in,
	input wire logic [1:0] dq_oe
);
	import psbi_pkg::*;
	logic drv;
	logic [DATA_W-1:0] wdat;
	logic [DATA_W-1:0] idle_q;
	// Released lanes toggle so stale data never passes as valid
	assign dq_in = drv ? wdat : idle_q;
	always @(posedge sys_clk) idle_q <= ~idle_q;
	task automatic wn(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wn
	// Select high ends any page sequence
	task automatic rel();
		chip_select_n <= 1'b1;
		output_enable_n <= 1'b1;
		write_enable_n <= 1'b1;
		{high_byte_enable_n, low_byte_enable_n} <= 2'b11;
		config_reg_select <= 1'b0;
		address_valid_n <= 1'b1;
		drv <= 1'b0;
	endtask : rel
	task automatic bus_close();
		rel();
		wn(8);
	endtask : bus_close
	initial begin
		bus_clk = 1'b0;
		idle_q = 16'h5a5a;
		wdat = 16'h0000;
		addr = '0;
		rel();
	end
	// Each pin state held at least 4 cycles; input filter needs 2
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [1:0] ben, input logic cfg, input logic lat);
		addr <= a;
		wdat <= d;
		drv <= 1'b1;
		address_valid_n <= 1'b0;
		chip_select_n <= 1'b0;
		output_enable_n <= cfg;
		write_enable_n <= 1'b0;
		{high_byte_enable_n, low_byte_enable_n} <= ben;
		config_reg_select <= cfg;
		wn(6);
		if (lat) begin
			address_valid_n <= 1'b1;
			wn(4);
			addr <= ~a;
			wn(4);
		end
		write_enable_n <= 1'b1;
		wn(6);
		bus_close();
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] ben, input logic lat,
		output logic ok);
		addr <= a;
		address_valid_n <= 1'b0;
		chip_select_n <= 1'b0;
		output_enable_n <= 1'b0;
		{high_byte_enable_n, low_byte_enable_n} <= ben;
		if (lat) begin
			wn(6);
			address_valid_n <= 1'b1;
			wn(4);
			addr <= ~a;
		end
		ok = 1'b0;
		for (int i = 0; i < 60 && !ok; i++) begin
			wn(1);
			ok = (dq_oe != 2'b00);
		end
		wn(2);
	endtask : rd
	// Page step: only the low address bits move, valid stays low
	task automatic pg(input logic [ADDR_W-1:0] a);
		addr <= a;
		wn(12);
	endtask : pg
	// Burst start: one bus clock rise with address valid low, write enable high
	task automatic bl(input logic [ADDR_W-1:0] a);
		addr <= a;
		address_valid_n <= 1'b0;
		chip_select_n <= 1'b0;
		wn(6);
		bus_clk <= 1'b1;
		wn(6);
		bus_clk <= 1'b0;
		wn(4);
	endtask : bl
endmodule : psbi_host

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import psbi_pkg::*;
	logic sys_clk, rst, ok, bus_clk, address_valid_n, chip_select_n, output_enable_n;
	logic write_enable_n, config_reg_select, low_byte_enable_n, high_byte_enable_n;
	logic wait_out, wait_oe, init_done, deep_power_down, burst_mode;
	logic [ADDR_W-1:0] addr, a;
	logic [DATA_W-1:0] dq_in, dq_out, d;
	logic [1:0] dq_oe, bw, br;
	logic [DATA_W-1:0] mem [256];
	logic [DATA_W-1:0] pgd [4];
	logic [31:0] r;
	int fail_count, n_checks, seed;
	// Short init count keeps the run brief
	psbi_top #(.INIT_CYCLES(20)) u_psbi_top (.sys_clk, .rst, .bus_clk, .address_valid_n,
		.chip_select_n, .output_enable_n, .write_enable_n, .config_reg_select,
		.low_byte_enable_n, .high_byte_enable_n, .addr, .dq_in, .dq_out, .dq_oe,
		.wait_out, .wait_oe, .init_done, .deep_power_down, .burst_mode);
	psbi_host u_psbi_host (.sys_clk, .bus_clk, .address_valid_n, .chip_select_n,
		.output_enable_n, .write_enable_n, .config_reg_select, .low_byte_enable_n,
		.high_byte_enable_n, .addr, .dq_in, .dq_oe);
	initial begin
		sys_clk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
	end
	function automatic logic [15:0] lm(input logic [1:0] ben);
		return {{8{~ben[1]}}, {8{~ben[0]}}};
	endfunction : lm
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", w, e, g);
			fail_count++;
		end
	endtask : chk
	task automatic rd_chk(input logic [ADDR_W-1:0] ra, input logic [1:0] ben, input logic lat,
		input logic [15:0] e);
		u_psbi_host.rd(ra, ben, lat, ok);
		chk("read answer", 1, ok);
		chk("lane enable", {30'h0, ~ben}, {30'h0, dq_oe});
		chk("read data", e & lm(ben), dq_out & lm(ben));
		chk("wait enable", 1, wait_oe);
	endtask : rd_chk
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		seed = 32'h63df1859;
		fail_count = 0;
		n_checks = 0;
		rst = 1'b1;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (5) @(posedge sys_clk);
		chk("init early", 0, init_done);
		for (int i = 0; i < 100 && init_done !== 1'b1; i++) @(posedge sys_clk);
		chk("init done", 1, init_done);
		chk("burst mode", 0, burst_mode);
		chk("deep power", 0, deep_power_down);
		chk("wait idle", 0, wait_oe);
		// Random words, byte lanes and address latch styles
		for (int i = 0; i < 10; i++) begin
			r = $random(seed);
			a = r[21:0];
			bw = (r[23:22] == 2'b11) ? 2'b00 : r[23:22];
			br = (r[25:24] == 2'b11) ? 2'b01 : r[25:24];
			r = $random(seed);
			u_psbi_host.wr(a, r[15:0], 2'b00, 1'b0, r[1]);
			u_psbi_host.wr(a, r[31:16], bw, 1'b0, 1'b0);
			mem[a[7:0]] = (r[15:0] & ~lm(bw)) | (r[31:16] & lm(bw));
			rd_chk(a, br, r[2], mem[a[7:0]]);
			chk("wait level", 0, wait_out);
			u_psbi_host.bus_close();
			chk("standby lanes", 0, dq_oe);
			chk("standby wait", 0, wait_oe);
		end
		// Config write must leave the array alone
		d = r[15:0];
		u_psbi_host.wr('0, d, 2'b00, 1'b0, 1'b0);
		u_psbi_host.wr(22'h080400, 16'hffff, 2'b00, 1'b1, 1'b0);
		rd_chk('0, 2'b00, 1'b0, d);
		chk("wait level", 1, wait_out);
		u_psbi_host.bus_close();
		// Page reads within one 16-word page
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			pgd[i] = {4'(i), r[11:0]};
			u_psbi_host.wr(22'h000120 + 22'(i), pgd[i], 2'b00, 1'b0, 1'b0);
		end
		u_psbi_host.wr(22'h000090, 16'hffff, 2'b00, 1'b1, 1'b0);
		rd_chk(22'h000120, 2'b00, 1'b0, pgd[0]);
		for (int i = 1; i < 4; i++) begin
			u_psbi_host.pg(22'h000120 + 22'(i));
			chk("page data", pgd[i], dq_out);
			chk("page lanes", 3, dq_oe);
		end
		u_psbi_host.bus_close();
		// Deep power-down ignores array writes until refresh config rewritten
		u_psbi_host.wr('0, 16'hffff, 2'b00, 1'b1, 1'b0);
		chk("dpd entry", 1, deep_power_down);
		u_psbi_host.wr('0, ~d, 2'b00, 1'b0, 1'b0);
		chk("dpd held", 1, deep_power_down);
		u_psbi_host.wr(22'h000010, 16'hffff, 2'b00, 1'b1, 1'b0);
		chk("dpd exit", 0, deep_power_down);
		rd_chk('0, 2'b00, 1'b0, d);
		u_psbi_host.bus_close();
		// Burst select turns off asynchronous reads
		u_psbi_host.wr(22'h088000, 16'hffff, 2'b00, 1'b1, 1'b0);
		chk("burst mode", 1, burst_mode);
		u_psbi_host.rd('0, 2'b00, 1'b0, ok);
		chk("burst async read", 0, ok);
		u_psbi_host.bus_close();
		// One clock rise with address valid low latches a burst address
		u_psbi_host.bl(22'h000055);
		chk("burst wait enable", 1, wait_oe);
		u_psbi_host.bus_close();
		report_and_stop();
	end
endmodule : tb_top
